/* File: verif/mii_rx_port_tb.sv */
// Self-checking bench for the receive port: register traffic and PHY frames.
// Assumes the PHY model in phy_model.sv and a 125 MHz CLK.
`timescale 1ns/10ps
`default_nettype none
module mii_rx_port_tb;
  import mii_rx_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        wb_we;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_ack;
  logic [3:0]  wb_adr;
  logic [31:0] wb_dat;
  logic [31:0] wb_q;
  logic        role;        // Port role strap
  logic        rtype;       // Interface type strap
  logic        coll;        // Collision input
  logic        lclk;        // Link clock from the PHY model
  logic        dv;
  logic        err;
  logic [3:0]  rxd;
  logic        rx_o;
  logic        rx_oe;
  logic        tx_o;
  logic        tx_oe;
  int          mismatches;
  int          cmp_count;
  int          n;
  logic        pv;
  // Clock pins resolve from whoever drives them
  mii_rx_port dut (.CLK(clk), .RESET_N(reset_n), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dat), .WB_DAT_O(wb_q),
    .WB_SEL_I(4'hF), .WB_WE_I(wb_we), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_ACK_O(wb_ack),
    .REF_CLK((role | rtype) & lclk), .RX_CLK_I(rx_oe ? rx_o : lclk), .RX_CLK_O(rx_o), .RX_CLK_OE(rx_oe),
    .TX_CLK_I(tx_oe ? tx_o : lclk), .TX_CLK_O(tx_o), .TX_CLK_OE(tx_oe), .RXD(rxd), .RX_DV(dv), .RX_ERR(err),
    .RECEIVE_CARRIER_IN(dv | role),
    .COLLISION_IN(coll), .PORT_ROLE_SELECT(role), .INTERFACE_TYPE_SELECT(rtype));
  phy_model phy (.CLK(clk), .RMII(rtype), .FREE(role | rtype), .LCLK(lclk), .RXD(rxd), .DV(dv), .ERR(err));
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    do
    begin
      @(posedge clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (k >= 50) mismatches++;
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // Expected data word
  function automatic logic [31:0] dw(input logic [7:0] b, input logic s, input logic e);
    return (32'h1 << DATA_VALID) | (32'(s) << DATA_SOF) | (32'(e) << DATA_ERR) | {24'h0, b};
  endfunction
  // Counts rising edges of the derived clock over 200 CLK
  task automatic edges();
    n = 0;
    pv = rx_o;
    for (int k = 0; k < 200; k++)
    begin
      @(posedge clk);
      if (rx_o && !pv) n++;
      // Transmit clock must track the receive clock, else the count is spoiled
      if (tx_o !== rx_o) n = 0;
      pv = rx_o;
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial
  begin
    {reset_n, wb_we, wb_cyc, wb_stb, role, rtype, coll} = 7'h00;
    wb_adr = 4'h0;
    wb_dat = 32'h0;
    mismatches = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(REG_CTRL, 32'hFF, {29'h0, CTRL_FULLDUP_RST, CTRL_SPEED_RST, CTRL_ENABLE_RST});
    wr(4'h2, 32'hFFFFFFFF);
    rd(4'h2, 32'hFFFFFFFF, 32'h0);
    wr(REG_CTRL, 32'h3);
    phy.send(8'hA5, 1'b1, 1'b0);
    phy.send(8'h3C, 1'b1, 1'b0);
    phy.idle();
    rd(REG_DATA, 32'hFFFFFFFF, dw(8'hA5, 1'b1, 1'b0));
    rd(REG_DATA, 32'hFFFFFFFF, dw(8'h3C, 1'b0, 1'b0));
    rd(REG_STATUS, 32'h8, 32'h8);
    phy.send(8'h77, 1'b0, 1'b1);
    phy.idle();
    rd(REG_DATA, 32'hFFFFFFFF, 32'h0);
    rd(REG_STATUS, 32'h2, 32'h0);
    phy.send(8'h11, 1'b1, 1'b1);
    phy.idle();
    rd(REG_STATUS, 32'h2, 32'h2);
    rd(REG_DATA, 32'hFFFFFFFF, dw(8'h11, 1'b1, 1'b1));
    // Collision in full duplex, then half duplex
    for (int fd = 1; fd >= 0; fd--)
    begin
      wr(REG_CTRL, fd ? 32'h7 : 32'h3);
      coll <= 1'b1;
      repeat (6) @(posedge clk);
      coll <= 1'b0;
      repeat (6) @(posedge clk);
      rd(REG_STATUS, 32'h1, fd ? 32'h0 : 32'h1);
    end
    // Fill the FIFO past its depth, then drain it
    wr(REG_BYTES, 32'h0);
    for (int i = 0; i <= FIFO_DEPTH; i++) phy.send(8'(i), 1'b1, 1'b0);
    phy.idle();
    rd(REG_BYTES, 32'hFFFFFFFF, 32'(FIFO_DEPTH));
    rd(REG_STATUS, 32'h4, 32'h4);
    for (int i = 0; i < FIFO_DEPTH; i++) rd(REG_DATA, 32'hFFFFFFFF, dw(8'(i), i == 0, 1'b0));
    rd(REG_DATA, 32'hFFFFFFFF, 32'h0);
    // RMII at 100 Mbps
    rtype <= 1'b1;
    repeat (8) @(posedge clk);
    rd(REG_STATUS, 32'h20, 32'h20);
    phy.send(8'h96, 1'b1, 1'b0);
    phy.send(8'h4B, 1'b1, 1'b0);
    phy.idle();
    rd(REG_DATA, 32'hFFFFFFFF, dw(8'h96, 1'b1, 1'b0));
    rd(REG_DATA, 32'hFFFFFFFF, dw(8'h4B, 1'b0, 1'b0));
    // RMII at 10 Mbps: each dibit held ten reference periods
    wr(REG_CTRL, 32'h1);
    phy.reps = 10;
    phy.send(8'hC3, 1'b1, 1'b0);
    phy.idle();
    rd(REG_DATA, 32'hFFFFFFFF, dw(8'hC3, 1'b1, 1'b0));
    wr(REG_CTRL, 32'h3);
    // DCE role: derived clocks at reference/2 and reference/20
    rtype <= 1'b0;
    role <= 1'b1;
    repeat (8) @(posedge clk);
    chk({30'h0, rx_oe, tx_oe}, 32'h3);
    rd(REG_STATUS, 32'h50, 32'h50);
    // DCE receive: one nibble per two reference periods, sampled on the derived clock
    phy.reps = 2;
    phy.send(8'h5A, 1'b1, 1'b0);
    phy.idle();
    rd(REG_DATA, 32'hFFFFFFFF, dw(8'h5A, 1'b1, 1'b0));
    edges();
    chk(32'(n >= 19 && n <= 21), 32'h1);
    wr(REG_CTRL, 32'h1);
    edges();
    chk(32'(n >= 1 && n <= 3), 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire

/* File: verif/phy_model.sv */
// PHY-side model: makes the link clock and sends nibbles (MII) or dibits (RMII).
// Assumes its tasks are called from the bench just after a CLK rising edge.
`timescale 1ns/10ps
`default_nettype none
module phy_model (
  input  wire logic       CLK,
  input  wire logic       RMII,
  input  wire logic       FREE,
  output logic            LCLK,
  output logic [3:0]      RXD,
  output logic            DV,
  output logic            ERR
);
  logic [2:0] ph  = 3'h0;  // Phase within five CLK periods
  logic       act = 1'b0;  // Frame in progress
  int         reps = 1;    // Link periods for which each group is held
  initial
  begin
    RXD = 4'h0;
    DV  = 1'b0;
    ERR = 1'b0;
  end
  // 25 MHz link clock, three CLK high and two low; parked low between frames unless free-running
  always @(posedge CLK)
    ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
  assign LCLK = (act | FREE) & (ph < 3'h3);
  // One group, launched as the link clock falls so it is stable at the next rising edge
  task automatic grp(input logic [3:0] d, input logic v, input logic e);
    do @(negedge CLK); while (ph != 3'h2);
    @(posedge CLK);
    act <= 1'b1;
    RXD <= v ? d : ~RXD;  // Released lines toggle
    DV  <= v;             // Carrier high exactly while data valid
    ERR <= e;
  endtask
  // One byte, first group in the low bits; each group held reps link periods
  task automatic send(input logic [7:0] b, input logic v, input logic e);
    if (RMII)
      for (int i = 0; i < 4; i++) repeat (reps) grp({2'h0, b[2*i+:2]}, v, e);
    else
      for (int i = 0; i < 2; i++) repeat (reps) grp(b[4*i+:4], v, e);
  endtask
  // Frame end: lines released, clock parked afterwards
  task automatic idle();
    grp(4'h0, 1'b0, 1'b0);
    grp(4'h0, 1'b0, 1'b0);
    @(posedge CLK);
    act <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verilog/mii_rx_pkg.sv */
// Constants shared by the receive port of the MII/RMII PHY interface.
// Assumes a 125 MHz system clock and a Wishbone slave with byte addresses.
package mii_rx_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [3:0] REG_CTRL   = 4'h0;   // Control: enable, speed, duplex
  localparam logic [3:0] REG_STATUS = 4'h4;   // Sticky events and strap levels
  localparam logic [3:0] REG_DATA   = 4'h8;   // Receive byte, read pops the FIFO
  localparam logic [3:0] REG_BYTES  = 4'hC;   // Accepted byte counter

  // Control register fields
  localparam int CTRL_ENABLE  = 0;            // Receive enable
  localparam int CTRL_SPEED   = 1;            // 1 = 100 Mbps, 0 = 10 Mbps
  localparam int CTRL_FULLDUP = 2;            // 1 = full duplex
  localparam logic CTRL_ENABLE_RST  = 1'b0;
  localparam logic CTRL_SPEED_RST   = 1'b1;
  localparam logic CTRL_FULLDUP_RST = 1'b0;

  // Status register fields
  localparam int ST_COLLISION = 0;            // Sticky, write one to clear
  localparam int ST_RXERROR   = 1;            // Sticky, write one to clear
  localparam int ST_OVERFLOW  = 2;            // Sticky, write one to clear
  localparam int ST_TXCLK     = 3;            // Sticky, transmit clock seen
  localparam int ST_ROLE      = 4;            // Port role strap level
  localparam int ST_TYPE      = 5;            // Interface type strap level
  localparam int ST_CARRIER   = 6;            // Carrier input level
  localparam int ST_FIFO_NE   = 7;            // FIFO holds a byte

  // Data register fields
  localparam int DATA_ERR   = 8;              // Byte saw a receive error
  localparam int DATA_SOF   = 9;              // First byte of a frame
  localparam int DATA_VALID = 31;             // Read returned a byte

  // FIFO shape
  localparam int FIFO_WIDTH = 10;             // {sof, err, byte}
  localparam int FIFO_DEPTH = 32;

  // Clock division from the reference clock (50 MHz)
  localparam logic [3:0] DIV_HALF_100 = 4'h1; // Ref edges per half period, 25 MHz
  localparam logic [3:0] DIV_HALF_10  = 4'hA; // Ref edges per half period, 2.5 MHz
  localparam logic [3:0] RMII_DECIM   = 4'hA; // Ref periods per sample at 10 Mbps

  // Groups per byte, minus one
  localparam logic [1:0] GRP_LAST_MII  = 2'h1;
  localparam logic [1:0] GRP_LAST_RMII = 2'h3;

  // Synchroniser bit positions
  localparam int S_REFCLK = 0;
  localparam int S_RXCLK  = 1;
  localparam int S_TXCLK  = 2;
  localparam int S_COL    = 3;
  localparam int S_CRS    = 4;
  localparam int S_DV     = 5;
  localparam int S_ERR    = 6;
  localparam int S_ROLE   = 7;
  localparam int S_TYPE   = 8;
  localparam int S_RXD    = 9;
  localparam int S_WIDTH  = 13;

  // Receive framing state
  typedef enum logic [0:0] {ST_IDLE, ST_FRAME} rx_state_t;

endpackage

/* File: verilog/mii_rx_port.sv */
// Receive side and clocking of the MII/RMII PHY port, with its byte FIFO.
// Assumes CLK at 125 MHz; all PHY pins are asynchronous and are synchronised.
// Function
// - Receive clock 25 MHz fast, 2.5 MHz slow
// - DTE takes receive clock; DCE drives it
// - Transmit clock same rates, sourced likewise
// - MII: four bits per rising edge, bit0 LSB
// - Drop MII data while data valid low
// - RMII fast: two bits per ref clock
// - RMII slow: one sample per ten periods
// - Receive error counts only with carrier
// - Collision honoured only in half duplex
// - Receive signals referenced to rising edge
// - RMII signals all on reference clock
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module rx_byte_fifo
  import mii_rx_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage array
  logic [AW:0]      wr_ptr_reg;    // Write pointer with wrap bit
  logic [AW:0]      rd_ptr_reg;    // Read pointer with wrap bit
  logic             push;          // Accepted write
  logic             pop;           // Accepted read

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

module mii_rx_port
  import mii_rx_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic             WB_ACK_O,
  input  wire logic        REF_CLK,
  input  wire logic        RX_CLK_I,
  output logic             RX_CLK_O,
  output logic             RX_CLK_OE,
  input  wire logic        TX_CLK_I,
  output logic             TX_CLK_O,
  output logic             TX_CLK_OE,
  input  wire logic [3:0]  RXD,
  input  wire logic        RX_DV,
  input  wire logic        RX_ERR,
  input  wire logic        RECEIVE_CARRIER_IN,
  input  wire logic        COLLISION_IN,
  input  wire logic        PORT_ROLE_SELECT,
  input  wire logic        INTERFACE_TYPE_SELECT
);

  // Shift a new group into the top of the byte, earlier groups move down
  function automatic logic [7:0] shift_group(input logic [7:0] cur, input logic [3:0] grp, input logic mii);
    if (mii)
      shift_group = {grp, cur[7:4]};
    else
      shift_group = {grp[1:0], cur[7:2]};
  endfunction

  logic [S_WIDTH-1:0] meta_reg;      // First synchroniser stage
  logic [S_WIDTH-1:0] sync_reg;      // Second synchroniser stage
  logic [S_WIDTH-1:0] dly_reg;       // Previous synchronised value
  logic               enable_reg;    // Receive enable
  logic               speed_reg;     // 100 Mbps when high
  logic               fulldup_reg;   // Full duplex when high
  logic               col_reg;       // Sticky collision
  logic               rxerr_reg;     // Sticky receive error
  logic               ovf_reg;       // Sticky FIFO overflow
  logic               txclk_reg;     // Sticky transmit clock activity
  logic [31:0]        bytes_reg;     // Accepted byte count
  logic [3:0]         div_reg;       // Reference edge divider
  logic               clk_gen_reg;   // Derived link clock
  logic               oe_reg;        // Clock pin drive enable
  logic [3:0]         decim_reg;     // RMII slow-rate decimation
  rx_state_t          state_reg;     // Framing state
  logic [1:0]         grp_reg;       // Groups collected in current byte
  logic [7:0]         shift_reg;     // Byte under assembly
  logic               sof_reg;       // Next byte opens a frame
  logic               err_acc_reg;   // Error seen in current byte
  logic               ack_reg;       // Bus acknowledge
  logic [31:0]        rdata_reg;     // Bus read data

  logic               dce_mii;       // Device drives the link clocks
  logic               rmii;          // RMII interface selected
  logic               ref_rise;      // Reference clock rising edge
  logic               rxclk_rise;    // Received clock rising edge
  logic [3:0]         half_cnt;      // Ref edges per derived half period
  logic               gen_rise;      // Derived clock about to rise
  logic               sample_edge;   // Moment at which receive pins are taken
  logic               valid_in;      // Data qualifier for this interface
  logic               carrier_in;    // Carrier qualifier
  logic [3:0]         rxd_in;        // Data pins before the edge
  logic               err_now;       // Error qualified by carrier
  logic [1:0]         grp_last;      // Last group index for the interface
  logic [7:0]         next_byte;     // Byte with the current group shifted in
  logic               push;          // Byte offered to the FIFO
  logic               in_ready;      // FIFO has room
  logic [FIFO_WIDTH-1:0] fifo_out;   // FIFO head
  logic               fifo_valid;    // FIFO not empty
  logic               bus_req;       // New bus access this cycle
  logic               wr_any;        // Register write with low byte lane
  logic               pop;           // Data register read takes the head

  // Static decodes of the synchronised pins
  assign rmii        = sync_reg[S_TYPE];
  assign dce_mii     = sync_reg[S_ROLE] && !rmii;
  assign ref_rise    = sync_reg[S_REFCLK] && !dly_reg[S_REFCLK];
  assign rxclk_rise  = sync_reg[S_RXCLK] && !dly_reg[S_RXCLK];
  assign half_cnt    = speed_reg ? DIV_HALF_100 : DIV_HALF_10;
  assign gen_rise    = ref_rise && (div_reg == half_cnt - 4'h1) && !clk_gen_reg;
  assign rxd_in      = dly_reg[S_RXD +: 4];
  assign carrier_in  = dly_reg[S_CRS];
  assign valid_in    = rmii ? carrier_in : dly_reg[S_DV];
  assign err_now     = dly_reg[S_ERR] && carrier_in;
  assign grp_last    = rmii ? GRP_LAST_RMII : GRP_LAST_MII;
  assign next_byte   = shift_group(shift_reg, rxd_in, !rmii);

  // Choose the sampling moment for the selected interface and role
  always_comb
  begin
    if (rmii)
      sample_edge = ref_rise && (speed_reg || decim_reg == 4'h0);
    else if (dce_mii)
      sample_edge = gen_rise;
    else
      sample_edge = rxclk_rise;
  end

  assign push    = sample_edge && enable_reg && valid_in && (grp_reg == grp_last);
  assign bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
  // Writes land at the edge where the master samples ack, its request still held
  assign wr_any  = WB_CYC_I && WB_STB_I && ack_reg && WB_WE_I && WB_SEL_I[0];
  assign pop     = bus_req && !WB_WE_I && (WB_ADR_I == REG_DATA) && fifo_valid;

  // Two flip-flops on every pin; a third stage feeds edge detection
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      dly_reg  <= '0;
    end
    else
    begin
      meta_reg <= {RXD, INTERFACE_TYPE_SELECT, PORT_ROLE_SELECT, RX_ERR, RX_DV,
                   RECEIVE_CARRIER_IN, COLLISION_IN, TX_CLK_I, RX_CLK_I, REF_CLK};
      sync_reg <= meta_reg;
      dly_reg  <= sync_reg;
    end
  end

  // Divide the reference clock into the link clock for the DCE role
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      div_reg     <= 4'h0;
      clk_gen_reg <= 1'b0;
      oe_reg      <= 1'b0;
    end
    else
    begin
      oe_reg <= dce_mii;
      if (!dce_mii)
      begin
        div_reg     <= 4'h0;
        clk_gen_reg <= 1'b0;
      end
      else if (ref_rise)
      begin
        if (div_reg >= half_cnt - 4'h1)
        begin
          div_reg     <= 4'h0;
          clk_gen_reg <= !clk_gen_reg;
        end
        else
        begin
          div_reg <= div_reg + 4'h1;
        end
      end
    end
  end

  // Both link clocks leave on the same derived waveform
  assign RX_CLK_O  = clk_gen_reg;
  assign TX_CLK_O  = clk_gen_reg;
  assign RX_CLK_OE = oe_reg;
  assign TX_CLK_OE = oe_reg;

  // RMII slow rate: count reference periods, restart when the frame starts
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      decim_reg <= 4'h0;
    end
    else if (ref_rise)
    begin
      if (!valid_in || decim_reg == RMII_DECIM - 4'h1)
        decim_reg <= 4'h0;
      else
        decim_reg <= decim_reg + 4'h1;
    end
  end

  // Framing and byte assembly
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      state_reg   <= ST_IDLE;
      grp_reg     <= 2'h0;
      shift_reg   <= 8'h00;
      sof_reg     <= 1'b0;
      err_acc_reg <= 1'b0;
    end
    else if (sample_edge)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          grp_reg     <= 2'h0;
          err_acc_reg <= 1'b0;
          if (valid_in && enable_reg)
          begin
            state_reg   <= ST_FRAME;
            sof_reg     <= 1'b1;
            shift_reg   <= next_byte;
            grp_reg     <= 2'h1;
            err_acc_reg <= err_now;
          end
        end
        ST_FRAME:
        begin
          if (!valid_in || !enable_reg)
          begin
            state_reg   <= ST_IDLE;
            grp_reg     <= 2'h0;
            err_acc_reg <= 1'b0;
          end
          else if (grp_reg == grp_last)
          begin
            grp_reg     <= 2'h0;
            sof_reg     <= 1'b0;
            err_acc_reg <= 1'b0;
          end
          else
          begin
            shift_reg   <= next_byte;
            grp_reg     <= grp_reg + 2'h1;
            err_acc_reg <= err_acc_reg || err_now;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Byte FIFO between the link and the bus
  rx_byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .in_valid  (push && state_reg == ST_FRAME),
    .in_ready  (in_ready),
    .in_data   ({sof_reg, err_acc_reg || err_now, next_byte}),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_out)
  );

  // Control register
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      enable_reg  <= CTRL_ENABLE_RST;
      speed_reg   <= CTRL_SPEED_RST;
      fulldup_reg <= CTRL_FULLDUP_RST;
    end
    else if (wr_any && WB_ADR_I == REG_CTRL)
    begin
      enable_reg  <= WB_DAT_I[CTRL_ENABLE];
      speed_reg   <= WB_DAT_I[CTRL_SPEED];
      fulldup_reg <= WB_DAT_I[CTRL_FULLDUP];
    end
  end

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      col_reg   <= 1'b0;
      rxerr_reg <= 1'b0;
      ovf_reg   <= 1'b0;
      txclk_reg <= 1'b0;
    end
    else
    begin
      if (dly_reg[S_COL] && !fulldup_reg && enable_reg)
        col_reg <= 1'b1;
      else if (wr_any && WB_ADR_I == REG_STATUS && WB_DAT_I[ST_COLLISION])
        col_reg <= 1'b0;
      if (err_now && enable_reg)
        rxerr_reg <= 1'b1;
      else if (wr_any && WB_ADR_I == REG_STATUS && WB_DAT_I[ST_RXERROR])
        rxerr_reg <= 1'b0;
      if (push && state_reg == ST_FRAME && !in_ready)
        ovf_reg <= 1'b1;
      else if (wr_any && WB_ADR_I == REG_STATUS && WB_DAT_I[ST_OVERFLOW])
        ovf_reg <= 1'b0;
      if (sync_reg[S_TXCLK] && !dly_reg[S_TXCLK])
        txclk_reg <= 1'b1;
      else if (wr_any && WB_ADR_I == REG_STATUS && WB_DAT_I[ST_TXCLK])
        txclk_reg <= 1'b0;
    end
  end

  // Count bytes stored; a write clears, a store in the same cycle leaves the count at one
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      bytes_reg <= 32'h0000_0000;
    else if (push && state_reg == ST_FRAME && in_ready)
      bytes_reg <= (wr_any && WB_ADR_I == REG_BYTES) ? 32'h0000_0001 : bytes_reg + 32'h0000_0001;
    else if (wr_any && WB_ADR_I == REG_BYTES)
      bytes_reg <= 32'h0000_0000;
  end

  // Wishbone answer one cycle after the request, dropped the next cycle
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= bus_req;
      if (bus_req && !WB_WE_I)
      begin
        rdata_reg <= 32'h0000_0000;
        if (WB_ADR_I == REG_CTRL)
        begin
          rdata_reg[CTRL_ENABLE]  <= enable_reg;
          rdata_reg[CTRL_SPEED]   <= speed_reg;
          rdata_reg[CTRL_FULLDUP] <= fulldup_reg;
        end
        else if (WB_ADR_I == REG_STATUS)
        begin
          rdata_reg[ST_COLLISION] <= col_reg;
          rdata_reg[ST_RXERROR]   <= rxerr_reg;
          rdata_reg[ST_OVERFLOW]  <= ovf_reg;
          rdata_reg[ST_TXCLK]     <= txclk_reg;
          rdata_reg[ST_ROLE]      <= sync_reg[S_ROLE];
          rdata_reg[ST_TYPE]      <= rmii;
          rdata_reg[ST_CARRIER]   <= sync_reg[S_CRS];
          rdata_reg[ST_FIFO_NE]   <= fifo_valid;
        end
        else if (WB_ADR_I == REG_DATA)
        begin
          rdata_reg[DATA_SOF:0]   <= fifo_valid ? fifo_out : '0;
          rdata_reg[DATA_VALID]   <= fifo_valid;
        end
        else if (WB_ADR_I == REG_BYTES)
        begin
          rdata_reg <= bytes_reg;
        end
      end
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;

  // Bus answer is a single-cycle pulse
  chk_ack_pulse: assert property (@(posedge CLK) disable iff (!RESET_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held for more than one cycle");

  // Clock pins driven whenever the role was DCE with MII the cycle before
  chk_dce_clock_drive: assert property (@(posedge CLK) disable iff (!RESET_N)
    $past(dce_mii) |-> (RX_CLK_OE && TX_CLK_OE))
    else $error("clock pins not driven in DCE role");

  // Derived clock toggles when the divider reaches its terminal count
  chk_divider_toggle: assert property (@(posedge CLK) disable iff (!RESET_N)
    (dce_mii && ref_rise && div_reg == half_cnt - 4'h1) |=> (clk_gen_reg != $past(clk_gen_reg)))
    else $error("derived clock missed its toggle");

  // Transmit clock follows the derived receive clock
  chk_tx_clk_follow: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_CLK_OE |-> (TX_CLK_O == RX_CLK_O))
    else $error("transmit clock differs from receive clock");

  // An unqualified sample leaves no group behind
  chk_invalid_dropped: assert property (@(posedge CLK) disable iff (!RESET_N)
    (sample_edge && !valid_in) |=> (grp_reg == 2'h0))
    else $error("group kept without data valid");

  // RMII slow rate takes samples only at decimation phase zero
  chk_rmii_decim: assert property (@(posedge CLK) disable iff (!RESET_N)
    (rmii && !speed_reg && sample_edge) |-> (decim_reg == 4'h0))
    else $error("RMII slow sample off its phase");

  // RMII bytes come only with carrier/data valid
  chk_rmii_carrier: assert property (@(posedge CLK) disable iff (!RESET_N)
    (push && rmii) |-> carrier_in)
    else $error("RMII byte taken without carrier");

  // Receive error raised only while carrier was present
  chk_err_carrier: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(rxerr_reg) |-> $past(dly_reg[S_ERR] && dly_reg[S_CRS]))
    else $error("error flagged without carrier");

  // Collision never flagged in full duplex
  chk_col_duplex: assert property (@(posedge CLK) disable iff (!RESET_N)
    (fulldup_reg && !col_reg) |=> !col_reg)
    else $error("collision taken in full duplex");

  // The latest group lands in the most significant bits
  chk_byte_order: assert property (@(posedge CLK) disable iff (!RESET_N)
    (push && state_reg == ST_FRAME && !rmii) |-> (next_byte[7:4] == rxd_in && next_byte[3:0] == shift_reg[7:4]))
    else $error("nibble order wrong");

endmodule

`default_nettype wire
